// >>> rtl/scp_pkg.sv
// package for the serial control port: constants, pin indices, state and bus types
//
// Overview of operation
// - Serial port works only when port select strap is 1; parallel port otherwise.
// - Mode strap 0 gives chip-select framing, 1 gives frame-sync framing.
// - Bit order strap 1 shifts MSB first, 0 LSB first, both directions.
// - Serial bit edges count only while chip select is low.
// - Serial output is open drain and only ever pulls low.
// - One transaction carries up to 127 data bytes.
// - Address byte is lowest block address LSB first, highest MSB first.
// - Instruction bit 7 is read flag, low seven bits the byte count.
// - Address steps up for order strap 0, down for 1, after each byte.
// - Input sampled and readback bits updated on serial clock rising edges.
// - Chip select may frame each byte or the whole transaction.
// - Eight bits are gathered before a byte goes to the register bus.
// - Serial output released except while readback bits are shifted.
// - Read: address and instruction written, then register data shifted out.
// - In frame-sync mode frame syncs are sampled on falling clock edges.
// - Frame-sync byte is eight rising edges after the sampled frame sync.
package scp_pkg;

   // byte framing
   localparam int         BYTE_BITS     = 8;
   localparam logic [2:0] BIT_FIRST     = 3'h0;
   localparam logic [2:0] BIT_LAST      = 3'h7;
   localparam int         RW_BIT        = 7;
   localparam int         CNT_MSB       = 6;
   localparam int         MAX_BLOCK     = 127;
   localparam logic [6:0] CNT_ZERO      = 7'h00;
   localparam logic [6:0] CNT_ONE       = 7'h01;
   localparam logic [7:0] ADDR_STEP     = 8'h01;
   localparam logic [7:0] ADDR_RST      = 8'h00;
   localparam logic [7:0] DATA_RST      = 8'h00;

   // strap encodings
   localparam logic       STRAP_SERIAL  = 1'b1;
   localparam logic       STRAP_FSYNC   = 1'b1;
   localparam logic       STRAP_MSB     = 1'b1;

   // synchroniser depth and pin slots
   localparam int         SYNC_STAGES   = 2;
   localparam int         PIN_SCLK      = 0;
   localparam int         PIN_DATA_IN   = 1;
   localparam int         PIN_CS_N      = 2;
   localparam int         PIN_RFS       = 3;
   localparam int         PIN_TFS       = 4;
   localparam int         PIN_PSEL      = 5;
   localparam int         PIN_MODE      = 6;
   localparam int         PIN_ORDER     = 7;
   localparam int         PIN_COUNT     = 8;

   typedef enum logic [1:0] {
      ST_ADDR,
      ST_INSTR,
      ST_WDATA,
      ST_RDATA
   } scp_state_t;

   // request toward the internal register space
   typedef struct packed {
      logic       wr_stb;
      logic       rd_stb;
      logic [7:0] addr;
      logic [7:0] wdata;
   } scp_reg_req_t;

endpackage

// >>> rtl/scp_sync.sv
// two-flop synchroniser bank with edge detection on the settled level
`timescale 1ns/10ps
module scp_sync
   import scp_pkg::*;
#(
   parameter int W = PIN_COUNT
) (
   // clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_reset,
   // asynchronous inputs
   input  wire logic [W-1:0] i_async,
   // synchronised level and edges
   output logic      [W-1:0] o_level,
   output logic      [W-1:0] o_rise,
   output logic      [W-1:0] o_fall
);

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic meta;
         logic stable;
         logic prev;
         always_ff @(posedge i_clk) begin
            if (i_reset) begin
               meta   <= 1'b0;
               stable <= 1'b0;
               prev   <= 1'b0;
            end else begin
               meta   <= i_async[g];
               stable <= meta;
               prev   <= stable;
            end
         end
         assign o_level[g] = stable;
         assign o_rise[g]  = stable & ~prev;
         assign o_fall[g]  = ~stable & prev;
      end
   endgenerate

endmodule

// >>> rtl/scp_port.sv
// serial control port: byte framing, transaction sequencing and open-drain readback
`timescale 1ns/10ps
module scp_port
   import scp_pkg::*;
(
   // clock and reset
   input  wire logic          i_clk,
   input  wire logic          i_reset,
   // serial pins
   input  wire logic          i_sclk,
   input  wire logic          i_serial_in,
   input  wire logic          i_serial_chip_select_n,
   input  wire logic          i_receive_frame_sync,
   input  wire logic          i_transmit_frame_sync,
   output logic               o_serial_out,
   output logic               o_serial_out_oe,
   // straps
   input  wire logic          i_port_select_strap,
   input  wire logic          i_frame_sync_serial_mode,
   input  wire logic          i_bit_order_strap,
   output logic               o_parallel_port_enable,
   // internal register bus
   output scp_reg_req_t       o_reg_req,
   input  wire logic [7:0]    i_reg_rdata
);

   logic [PIN_COUNT-1:0] pin_async;
   logic [PIN_COUNT-1:0] pin_lvl;
   logic [PIN_COUNT-1:0] pin_rise;
   logic [PIN_COUNT-1:0] pin_fall;

   scp_state_t state;
   scp_state_t next_state;
   logic [2:0] bit_cnt;
   logic [7:0] rx_sh;
   logic [7:0] cur_addr;
   logic [6:0] xfer_cnt;
   logic       armed;
   logic       busy;
   logic [7:0] tx_byte;
   logic       tx_bit;
   logic       tx_act;
   logic       rd_cap;

   assign pin_async[PIN_SCLK]  = i_sclk;
   assign pin_async[PIN_DATA_IN] = i_serial_in;
   assign pin_async[PIN_CS_N]  = i_serial_chip_select_n;
   assign pin_async[PIN_RFS]   = i_receive_frame_sync;
   assign pin_async[PIN_TFS]   = i_transmit_frame_sync;
   assign pin_async[PIN_PSEL]  = i_port_select_strap;
   assign pin_async[PIN_MODE]  = i_frame_sync_serial_mode;
   assign pin_async[PIN_ORDER] = i_bit_order_strap;

   scp_sync #(
      .W       (PIN_COUNT)
   ) u_sync (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_async (pin_async),
      .o_level (pin_lvl),
      .o_rise  (pin_rise),
      .o_fall  (pin_fall)
   );

   // decoded pin views
   wire serial_en = (pin_lvl[PIN_PSEL] == STRAP_SERIAL);
   wire spi_mode  = (pin_lvl[PIN_MODE] != STRAP_FSYNC);
   wire msb_first = (pin_lvl[PIN_ORDER] == STRAP_MSB);
   wire cs_low    = ~pin_lvl[PIN_CS_N];
   wire sclk_rise = pin_rise[PIN_SCLK];
   wire sclk_fall = pin_fall[PIN_SCLK];
   wire ser_in    = pin_lvl[PIN_DATA_IN];
   wire in_read   = (state == ST_RDATA);
   wire in_data   = (state == ST_WDATA) || (state == ST_RDATA);

   // frame sync: transmit sync only matters while readback is due
   wire fs_seen   = in_read ? pin_lvl[PIN_TFS] : pin_lvl[PIN_RFS];
   wire arm_now   = serial_en & cs_low & ~spi_mode & sclk_fall & fs_seen & ~busy;

   // a bit edge: rising clock, selected, and in chip-select mode or inside a frame-sync byte group
   wire bit_edge  = serial_en & cs_low & sclk_rise & (spi_mode | busy | armed);
   wire byte_done = bit_edge & (bit_cnt == BIT_LAST);

   wire [7:0] rx_next   = msb_first ? {rx_sh[6:0], ser_in} : {ser_in, rx_sh[7:1]};
   wire [2:0] tx_idx    = msb_first ? (BIT_LAST - bit_cnt) : bit_cnt;
   wire [7:0] step_addr = msb_first ? (cur_addr - ADDR_STEP)
                                    : (cur_addr + ADDR_STEP);
   wire       last_byte = (xfer_cnt == CNT_ONE);
   wire       instr_rd  = rx_next[RW_BIT];
   wire [6:0] instr_cnt = rx_next[CNT_MSB:0];
   wire       fetch_now = byte_done & (((state == ST_INSTR) & instr_rd & (instr_cnt != CNT_ZERO))
                                       | (in_read & ~last_byte));

   // transaction sequencing
   always_comb begin
      next_state = state;
      case (state)
         ST_ADDR: begin
            if (byte_done) begin
               next_state = ST_INSTR;
            end
         end
         ST_INSTR: begin
            if (byte_done) begin
               if (instr_cnt == CNT_ZERO) begin
                  next_state = ST_ADDR;
               end else if (instr_rd) begin
                  next_state = ST_RDATA;
               end else begin
                  next_state = ST_WDATA;
               end
            end
         end
         ST_WDATA, ST_RDATA: begin
            if (byte_done && last_byte) begin
               next_state = ST_ADDR;
            end
         end
         default: begin
            next_state = ST_ADDR;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_reset || !serial_en) begin
         state <= ST_ADDR;
      end else begin
         state <= next_state;
      end
   end

   // bit counter survives chip select high so per-byte select works
   always_ff @(posedge i_clk) begin
      if (i_reset || !serial_en) begin
         bit_cnt <= BIT_FIRST;
         rx_sh   <= DATA_RST;
      end else if (bit_edge) begin
         bit_cnt <= bit_cnt + 3'h1;
         rx_sh   <= rx_next;
      end
   end

   // frame-sync group tracking
   always_ff @(posedge i_clk) begin
      if (i_reset || !serial_en || spi_mode) begin
         armed <= 1'b0;
         busy  <= 1'b0;
      end else begin
         if (arm_now) begin
            armed <= 1'b1;
         end else if (bit_edge) begin
            armed <= 1'b0;
         end
         if (byte_done) begin
            busy <= 1'b0;
         end else if (bit_edge) begin
            busy <= 1'b1;
         end
      end
   end

   // address and count
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         cur_addr <= ADDR_RST;
         xfer_cnt <= CNT_ZERO;
      end else if (byte_done) begin
         case (state)
            ST_ADDR: begin
               cur_addr <= rx_next;
            end
            ST_INSTR: begin
               xfer_cnt <= instr_cnt;
            end
            ST_WDATA, ST_RDATA: begin
               cur_addr <= step_addr;
               xfer_cnt <= xfer_cnt - CNT_ONE;
            end
            default: begin
               cur_addr <= cur_addr;
            end
         endcase
      end
   end

   // register bus requests
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_reg_req <= '0;
         rd_cap    <= 1'b0;
         tx_byte   <= DATA_RST;
      end else begin
         o_reg_req.wr_stb <= byte_done & (state == ST_WDATA);
         o_reg_req.rd_stb <= fetch_now;
         rd_cap           <= o_reg_req.rd_stb;
         if (byte_done && state == ST_WDATA) begin
            o_reg_req.addr  <= cur_addr;
            o_reg_req.wdata <= rx_next;
         end else if (fetch_now) begin
            o_reg_req.addr  <= in_read ? step_addr : cur_addr;
         end
         if (rd_cap) begin
            tx_byte <= i_reg_rdata;
         end
      end
   end

   // readback shifter: bits change on rising serial clock, and are released when chip select goes high
   always_ff @(posedge i_clk) begin
      if (i_reset || !serial_en || !cs_low) begin
         tx_act <= 1'b0;
         tx_bit <= 1'b1;
      end else if (sclk_rise) begin
         tx_act <= bit_edge & in_read;
         if (bit_edge && in_read) begin
            tx_bit <= tx_byte[tx_idx];
         end
      end
   end

   assign o_serial_out           = 1'b0;
   assign o_serial_out_oe        = tx_act & ~tx_bit;
   assign o_parallel_port_enable = ~serial_en;

   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   sequence s_instr_read;
      state == ST_INSTR && byte_done && instr_rd && instr_cnt != CNT_ZERO;
   endsequence

   sequence s_fetch_done;
      o_reg_req.rd_stb && state == ST_RDATA ##1 rd_cap;
   endsequence

   sequence s_fs_sampled;
      arm_now;
   endsequence

   property p_port_off;
      !serial_en |=> !o_serial_out_oe && !o_reg_req.wr_stb && !o_reg_req.rd_stb;
   endproperty
   a_port_off: assert property (p_port_off)
      else $error("serial port active while parallel port selected");

   property p_cs_gate;
      o_reg_req.wr_stb |-> $past(cs_low);
   endproperty
   a_cs_gate: assert property (p_cs_gate)
      else $error("write issued without chip select low");

   property p_open_drain;
      o_serial_out_oe |-> (o_serial_out == 1'b0);
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("serial output driven high");

   property p_oe_read;
      $rose(o_serial_out_oe) |-> $past(state == ST_RDATA);
   endproperty
   a_oe_read: assert property (p_oe_read)
      else $error("serial output driven outside readback");

   property p_write_byte;
      o_reg_req.wr_stb |-> $past(byte_done && state == ST_WDATA);
   endproperty
   a_write_byte: assert property (p_write_byte)
      else $error("write strobe without a full byte");

   property p_addr_step;
      (byte_done && in_data)
         |=> cur_addr == ($past(msb_first) ? $past(cur_addr) - ADDR_STEP
                                           : $past(cur_addr) + ADDR_STEP);
   endproperty
   a_addr_step: assert property (p_addr_step)
      else $error("address did not step by one in the strap direction");

   property p_block_end;
      (byte_done && in_data && last_byte) |=> state == ST_ADDR;
   endproperty
   a_block_end: assert property (p_block_end)
      else $error("transaction did not end after its byte count");

   property p_read_fetch;
      s_instr_read |=> s_fetch_done;
   endproperty
   a_read_fetch: assert property (p_read_fetch)
      else $error("read instruction did not fetch register data");

   property p_rise_only;
      ($past(serial_en) && bit_cnt != $past(bit_cnt)) |-> $past(sclk_rise);
   endproperty
   a_rise_only: assert property (p_rise_only)
      else $error("bit counter moved without a rising serial clock");

   property p_fs_arm;
      s_fs_sampled |=> armed && !spi_mode;
   endproperty
   a_fs_arm: assert property (p_fs_arm)
      else $error("sampled frame sync did not arm a byte");

   property p_group;
      (armed && bit_edge && !byte_done) |=> busy && bit_cnt == (BIT_FIRST + 3'h1);
   endproperty
   a_group: assert property (p_group)
      else $error("frame sync group did not start on the next rising edge");

   property p_decode;
      (state == ST_INSTR && byte_done && instr_cnt != CNT_ZERO)
         |=> state == ($past(instr_rd) ? ST_RDATA : ST_WDATA);
   endproperty
   a_decode: assert property (p_decode)
      else $error("instruction direction flag decoded wrongly");

   property p_strobe_excl;
      !(o_reg_req.wr_stb && o_reg_req.rd_stb);
   endproperty
   a_strobe_excl: assert property (p_strobe_excl)
      else $error("read and write strobes raised together");

   property p_cs_hold;
      (serial_en && !cs_low) |=> $stable(bit_cnt) && !o_serial_out_oe;
   endproperty
   a_cs_hold: assert property (p_cs_hold)
      else $error("serial activity while chip select high");

   property p_wdata;
      o_reg_req.wr_stb |-> o_reg_req.wdata == $past(rx_next);
   endproperty
   a_wdata: assert property (p_wdata)
      else $error("written byte differs from the gathered bits");

   sequence s_zero_count;
      state == ST_INSTR && byte_done && instr_cnt == CNT_ZERO;
   endsequence

   property p_zero_count;
      s_zero_count |=> state == ST_ADDR && !o_reg_req.rd_stb && !o_reg_req.wr_stb;
   endproperty
   a_zero_count: assert property (p_zero_count)
      else $error("zero byte count did not return to address");

endmodule

// >>> dv/scp_host.sv
// host model: serial master driving clock, data, select and frame syncs
`timescale 1ns/10ps
module scp_host (
   // clock
   input  wire logic i_clk,
   // straps and open-drain line seen by the host
   input  wire logic i_mode,
   input  wire logic i_order,
   input  wire logic i_line,
   // serial pins toward the port
   output logic      o_sclk,
   output logic      o_din,
   output logic      o_cs_n,
   output logic      o_rfs,
   output logic      o_tfs
);
   logic pb = 1'b0;
   initial begin
      o_sclk = 1'b0;
      o_din = 1'b0;
      o_cs_n = 1'b1;
      o_rfs = 1'b0;
      o_tfs = 1'b0;
   end
   task automatic half();
      repeat (10) @(posedge i_clk);
      #1;
   endtask
   // data set while clock low, frame syncs dropped at the next rise
   task automatic cyc(input logic d, output logic q);
      o_din = d;
      half();
      o_rfs = 1'b0;
      o_tfs = 1'b0;
      o_sclk = 1'b1;
      half();
      q = i_line;
      o_sclk = 1'b0;
   endtask
   task automatic end_sel();
      half();
      o_cs_n = 1'b1;
      half();
   endtask
   task automatic xbyte(input logic [7:0] tx, input logic rd, output logic [7:0] rx,
                        output logic ok);
      logic q;
      ok = 1'b1;
      o_cs_n = 1'b0;
      if (i_mode) begin
         half();
         o_sclk = 1'b1;
         if (rd) o_tfs = 1'b1;
         else o_rfs = 1'b1;
         half();
         o_sclk = 1'b0;
      end
      for (int i = 0; i < 8; i++) begin
         cyc(i_order ? tx[7-i] : tx[i], q);
         if (i_order) rx[7-i] = q;
         else rx[i] = q;
         if (!rd && !q) ok = 1'b0;
      end
      o_din = ~o_din;
      if (pb) end_sel();
   endtask
endmodule

// >>> dv/tb_top.sv
// testbench top: host model, register space responder and request scoreboard
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((e) !== (g)) begin fail_count++; \
   $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_top
   import scp_pkg::*;
;
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   logic         psel = 1'b1;
   logic         mode = 1'b0;
   logic         order = 1'b0;
   logic         sclk, ser_in, cs_n, rfs, tfs, ser_out, ser_oe, par_en, ok;
   wire  logic   ser_line;
   logic [7:0]   rdata = 8'h00;
   logic [7:0]   r;
   scp_reg_req_t req;
   scp_reg_req_t exp_q[$];
   int           fail_count = 0;
   int           checks = 0;
   always #2 clk = ~clk;
   // open-drain line with pull-up
   assign ser_line = ser_oe ? ser_out : 1'b1;
   scp_host u_host (.i_clk(clk), .i_mode(mode), .i_order(order), .i_line(ser_line),
      .o_sclk(sclk), .o_din(ser_in), .o_cs_n(cs_n), .o_rfs(rfs), .o_tfs(tfs));
   scp_port u_dut (.i_clk(clk), .i_reset(rst), .i_sclk(sclk), .i_serial_in(ser_in),
      .i_serial_chip_select_n(cs_n), .i_receive_frame_sync(rfs),
      .i_transmit_frame_sync(tfs), .o_serial_out(ser_out), .o_serial_out_oe(ser_oe),
      .i_port_select_strap(psel), .i_frame_sync_serial_mode(mode),
      .i_bit_order_strap(order), .o_parallel_port_enable(par_en), .o_reg_req(req),
      .i_reg_rdata(rdata));
   function automatic logic [7:0] pat(input logic [7:0] a);
      return ~a ^ 8'h3c;
   endfunction
   // register space answers and oldest expected request is compared
   always @(posedge clk) begin
      scp_reg_req_t e, g;
      if (req.rd_stb) rdata <= pat(req.addr);
      if (req.wr_stb || req.rd_stb) begin
         g = req;
         if (!g.wr_stb) g.wdata = 8'h00;
         e = '0;
         if (exp_q.size() != 0) e = exp_q.pop_front();
         `CHK("request", e, g)
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic trans(input logic rd, input logic [7:0] a, input int n);
      logic [7:0] d, ea;
      if (rd) exp_q.push_back('{1'b0, 1'b1, a, 8'h00});
      u_host.xbyte(a, 1'b0, r, ok);
      `CHK("out idle", 1'b1, ok)
      u_host.xbyte({rd, n[6:0]}, 1'b0, r, ok);
      for (int k = 0; k < n; k++) begin
         ea = order ? a - k[7:0] : a + k[7:0];
         d = 8'($urandom);
         if (!rd) exp_q.push_back('{1'b1, 1'b0, ea, d});
         else if (k + 1 < n)
            exp_q.push_back('{1'b0, 1'b1, order ? ea - 8'h01 : ea + 8'h01, 8'h00});
         u_host.xbyte(d, rd, r, ok);
         if (rd) `CHK("readback", pat(ea), r)
         else `CHK("out idle", 1'b1, ok)
      end
      u_host.end_sel();
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #240000;
      fail_count++;
      end_of_test();
   end
   initial begin
      void'($urandom(3));
      step(6);
      rst = 1'b0;
      step(6);
      // every framing mode and bit order: block write then block read
      for (int m = 0; m < 4; m++) begin
         mode = m[1];
         order = m[0];
         u_host.pb = (m == 1);
         step(8);
         trans(1'b0, 8'($urandom), 3);
         trans(1'b1, 8'($urandom), 2);
      end
      $display("test 1 done");
      mode = 1'b0;
      u_host.pb = 1'b0;
      step(8);
      trans(1'b0, 8'h05, 127);
      $display("test 2 done");
      // zero count: next byte starts a new transaction
      u_host.xbyte(8'($urandom), 1'b0, r, ok);
      u_host.xbyte(8'h00, 1'b0, r, ok);
      trans(1'b0, 8'($urandom), 1);
      $display("test 3 done");
      // clock edges with select high must not shift
      for (int i = 0; i < 8; i++) u_host.cyc(1'($urandom), ok);
      trans(1'b1, 8'($urandom), 1);
      $display("test 4 done");
      psel = 1'b0;
      step(8);
      `CHK("parallel enable", 1'b1, par_en)
      for (int i = 0; i < 3; i++) u_host.xbyte(8'h01, 1'b0, r, ok);
      `CHK("out idle", 1'b1, ok)
      u_host.end_sel();
      psel = 1'b1;
      step(8);
      `CHK("parallel enable", 1'b0, par_en)
      trans(1'b0, 8'($urandom), 2);
      $display("test 5 done");
      step(40);
      `CHK("pending", 0, exp_q.size())
      `CHK("oe", 1'b0, ser_oe)
      end_of_test();
   end
endmodule
